// file: rtl/usbcf_pkg.sv
package usbcf_pkg;
    // register numbers, used directly as the configuration address
    localparam logic [7:0] USBCF_ADDR_IDENT = 8'h00;
    localparam logic [7:0] USBCF_ADDR_SETUP = 8'h04;
    localparam logic [7:0] USBCF_ADDR_NODE = 8'h05;
    localparam logic [7:0] USBCF_ADDR_CLK = 8'h51;
    localparam logic [7:0] USBCF_ADDR_LINK = 8'h80;
    // identification word fields
    localparam int USBCF_CHIP_LSB = 24;
    localparam int USBCF_REV_LSB = 8;
    localparam int USBCF_VER_LSB = 0;
    // node setup fields
    localparam int USBCF_LOCK_BIT = 31;
    localparam int USBCF_HDR_BIT = 0;
    localparam logic USBCF_HDR_RESET = 1'b0;
    // node number field
    localparam int USBCF_NODE_W = 16;
    localparam logic [15:0] USBCF_NODE_RESET = 16'h0000;
    // clock frequency field
    localparam int USBCF_CLK_W = 7;
    localparam logic [6:0] USBCF_CLK_RESET = 7'h19;
    localparam logic [6:0] USBCF_CLK_MIN = 7'h05;
    localparam logic [6:0] USBCF_CLK_MAX = 7'h64;
    // link control and status fields
    localparam int USBCF_RXERR_BIT = 27;
    localparam int USBCF_RXCRED_BIT = 26;
    localparam int USBCF_TXCRED_BIT = 25;
    localparam int USBCF_GREETING_TOKEN_BIT = 24;
    localparam int USBCF_RXRST_BIT = 23;
    localparam int USBCF_GAP_W = 11;
    localparam int USBCF_SYMGAP_LSB = 11;
    localparam int USBCF_TOKGAP_LSB = 0;
    localparam logic [10:0] USBCF_GAP_RESET = 11'h001;
endpackage

// file: rtl/usbcf_gap_timer.sv
`timescale 1ns/1ps
// holds the transmitter off for gap plus one idle clocks after each event
module usbcf_gap_timer (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // programmed gap and transmit event
    input wire logic [usbcf_pkg::USBCF_GAP_W-1:0] gap,
    input wire logic sent,
    // permission to send the next unit
    output logic ready_q
);
    import usbcf_pkg::*;

    logic [USBCF_GAP_W:0] count_q;
    logic [USBCF_GAP_W:0] count_d;
    logic ready_d;
    wire logic [USBCF_GAP_W:0] gap_plus_one = {1'b0, gap} + {{USBCF_GAP_W{1'b0}}, 1'b1};

    // load on every event, count idle clocks down to zero
    always_comb begin
        count_d = count_q;
        ready_d = ready_q;
        if (sent) begin
            count_d = gap_plus_one;
            ready_d = 1'b0;
        end else if (count_q > {(USBCF_GAP_W+1){1'b0}}) begin
            count_d = count_q - {{USBCF_GAP_W{1'b0}}, 1'b1};
            ready_d = (count_d == {(USBCF_GAP_W+1){1'b0}});
        end
    end

    // counter and ready flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
            ready_q <= 1'b1;
        end else begin
            count_q <= count_d;
            ready_q <= ready_d;
        end
    end
endmodule

// file: rtl/usbcf_node_regs.sv
`timescale 1ns/1ps
// configuration register bank of the node, answering config transactions
module usbcf_node_regs #(
    parameter logic [7:0] CHIP_CODE = 8'h5a, // arbitrary value
    parameter logic [7:0] BLOCK_REVISION = 8'h01, // arbitrary value
    parameter logic [7:0] BLOCK_VERSION = 8'h03 // arbitrary value
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // configuration transaction request
    input wire logic cfg_req,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    // configuration transaction answer
    output logic cfg_ack,
    output logic cfg_nack,
    output logic [31:0] cfg_rdata,
    // receiver events and credit state from the link logic
    input wire logic rx_overflow,
    input wire logic rx_bad_token,
    input wire logic rx_credit_issued,
    input wire logic tx_credit_grant,
    // strobes to the link logic
    output logic greeting_strobe,
    output logic receiver_reset_strobe,
    // transmitter pacing
    input wire logic tx_symbol_done,
    input wire logic tx_token_done,
    output logic tx_symbol_ok,
    output logic tx_token_ok,
    // settings to the rest of the node
    output logic header_format_select,
    output logic [usbcf_pkg::USBCF_NODE_W-1:0] node_number_field,
    output logic [usbcf_pkg::USBCF_CLK_W-1:0] clock_mhz_field,
    output logic locked
);
    import usbcf_pkg::*;

    // range check used on the clock field
    function automatic logic clk_in_range(input logic [USBCF_CLK_W-1:0] v);
        clk_in_range = (v >= USBCF_CLK_MIN) && (v <= USBCF_CLK_MAX);
    endfunction

    // reset release through two flip-flops
    logic rst_meta_q;
    logic rst_n;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // stored state
    logic lock_q;
    logic hdr_q;
    logic [USBCF_NODE_W-1:0] node_q;
    logic [USBCF_CLK_W-1:0] clk_q;
    logic [USBCF_GAP_W-1:0] symgap_q;
    logic [USBCF_GAP_W-1:0] tokgap_q;
    logic rxerr_q;
    logic rxcred_q;
    logic txcred_q;
    logic ack_q;
    logic nack_q;
    logic [31:0] rdata_q;
    logic greeting_token_q;
    logic rxrst_q;

    // address decode of a configuration transaction
    wire logic hit_ident = (cfg_addr == USBCF_ADDR_IDENT);
    wire logic hit_setup = (cfg_addr == USBCF_ADDR_SETUP);
    wire logic hit_node = (cfg_addr == USBCF_ADDR_NODE);
    wire logic hit_clk = (cfg_addr == USBCF_ADDR_CLK);
    wire logic hit_link = (cfg_addr == USBCF_ADDR_LINK);
    wire logic hit_any = hit_ident | hit_setup | hit_node | hit_clk | hit_link;

    // write qualification: lock, read-only word and clock range
    wire logic wr_req = cfg_req & cfg_write;
    wire logic [USBCF_CLK_W-1:0] wr_clk_val = cfg_wdata[USBCF_CLK_W-1:0];
    wire logic wr_ok = wr_req & ~lock_q & hit_any & ~hit_ident;
    wire logic clk_bad = hit_clk & ~clk_in_range(wr_clk_val);
    wire logic wr_setup = wr_ok & hit_setup;
    wire logic wr_node = wr_ok & hit_node;
    wire logic wr_clk = wr_ok & hit_clk & ~clk_bad;
    wire logic wr_link = wr_ok & hit_link;
    wire logic wr_greeting_token = wr_link & cfg_wdata[USBCF_GREETING_TOKEN_BIT];
    wire logic wr_rxrst = wr_link & cfg_wdata[USBCF_RXRST_BIT];

    // write data fields
    wire logic wr_lock_bit = cfg_wdata[USBCF_LOCK_BIT];
    wire logic wr_hdr_bit = cfg_wdata[USBCF_HDR_BIT];
    wire logic [USBCF_NODE_W-1:0] wr_node_val = cfg_wdata[USBCF_NODE_W-1:0];
    wire logic [USBCF_GAP_W-1:0] wr_symgap_val = cfg_wdata[USBCF_SYMGAP_LSB +: USBCF_GAP_W];
    wire logic [USBCF_GAP_W-1:0] wr_tokgap_val = cfg_wdata[USBCF_TOKGAP_LSB +: USBCF_GAP_W];

    // answer: nack for unmapped, locked, read-only or out-of-range writes
    wire logic nack_unmapped = ~hit_any;
    wire logic nack_refused = cfg_write & (~wr_ok | clk_bad);
    wire logic ans_nack = cfg_req & (nack_unmapped | nack_refused);
    wire logic ans_ack = cfg_req & ~ans_nack;

    // read words, reserved bits zero
    wire logic [31:0] rd_ident = ({24'h000000, CHIP_CODE} << USBCF_CHIP_LSB)
        | ({24'h000000, BLOCK_REVISION} << USBCF_REV_LSB)
        | ({24'h000000, BLOCK_VERSION} << USBCF_VER_LSB);
    wire logic [31:0] rd_setup = ({31'h00000000, lock_q} << USBCF_LOCK_BIT)
        | ({31'h00000000, hdr_q} << USBCF_HDR_BIT);
    wire logic [31:0] rd_node = {16'h0000, node_q};
    wire logic [31:0] rd_clk = {25'h0000000, clk_q};
    wire logic [31:0] rd_link = ({31'h00000000, rxerr_q} << USBCF_RXERR_BIT)
        | ({31'h00000000, rxcred_q} << USBCF_RXCRED_BIT)
        | ({31'h00000000, txcred_q} << USBCF_TXCRED_BIT)
        | ({21'h000000, symgap_q} << USBCF_SYMGAP_LSB)
        | ({21'h000000, tokgap_q} << USBCF_TOKGAP_LSB); // strobes read zero
    wire logic [31:0] rd_mux = hit_ident ? rd_ident :
        hit_setup ? rd_setup :
        hit_node ? rd_node :
        hit_clk ? rd_clk :
        hit_link ? rd_link : 32'h00000000;
    wire logic [31:0] rdata_d = (cfg_req & ~cfg_write) ? rd_mux : 32'h00000000;

    // next values of the link status flags; for rxerr and txcred set wins over clear, rxcred follows its input
    wire logic rxerr_set = rx_overflow | rx_bad_token;
    wire logic rxerr_d = rxerr_set | (rxerr_q & ~wr_rxrst);
    wire logic rxcred_d = rx_credit_issued;
    wire logic txcred_d = tx_credit_grant | (txcred_q & ~wr_greeting_token);

    // next lock and header mode; lock only ever sets
    wire logic lock_d = lock_q | (wr_setup & wr_lock_bit);
    wire logic hdr_d = wr_setup ? wr_hdr_bit : hdr_q;

    // next node number and clock field; bad clock values never land
    wire logic [USBCF_NODE_W-1:0] node_d = wr_node ? wr_node_val : node_q;
    wire logic [USBCF_CLK_W-1:0] clk_d = wr_clk ? wr_clk_val : clk_q;

    // next gap fields, both rewritten by any link word write
    wire logic [USBCF_GAP_W-1:0] symgap_d = wr_link ? wr_symgap_val : symgap_q;
    wire logic [USBCF_GAP_W-1:0] tokgap_d = wr_link ? wr_tokgap_val : tokgap_q;

    // next strobes and answer
    wire logic greeting_token_d = wr_greeting_token;
    wire logic rxrst_d = wr_rxrst;
    wire logic ack_d = ans_ack;
    wire logic nack_d = ans_nack;

    // lock bit, once set held until reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_q <= 1'b0;
        end else begin
            lock_q <= lock_d;
        end
    end

    // header mode
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hdr_q <= USBCF_HDR_RESET;
        end else begin
            hdr_q <= hdr_d;
        end
    end

    // node number
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            node_q <= USBCF_NODE_RESET;
        end else begin
            node_q <= node_d;
        end
    end

    // clock frequency, reset twenty-five, kept on a bad write
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_q <= USBCF_CLK_RESET;
        end else begin
            clk_q <= clk_d;
        end
    end

    // symbol gap field
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            symgap_q <= USBCF_GAP_RESET;
        end else begin
            symgap_q <= symgap_d;
        end
    end

    // token gap field
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tokgap_q <= USBCF_GAP_RESET;
        end else begin
            tokgap_q <= tokgap_d;
        end
    end

    // receive error, sticky until receiver reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxerr_q <= 1'b0;
        end else begin
            rxerr_q <= rxerr_d;
        end
    end

    // credit issued to the remote end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxcred_q <= 1'b0;
        end else begin
            rxcred_q <= rxcred_d;
        end
    end

    // credit held by this end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            txcred_q <= 1'b0;
        end else begin
            txcred_q <= txcred_d;
        end
    end

    // greeting strobe, one cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            greeting_token_q <= 1'b0;
        end else begin
            greeting_token_q <= greeting_token_d;
        end
    end

    // receiver reset strobe, one cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxrst_q <= 1'b0;
        end else begin
            rxrst_q <= rxrst_d;
        end
    end

    // accept answer one clock after the request
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end

    // refuse answer one clock after the request
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            nack_q <= 1'b0;
        end else begin
            nack_q <= nack_d;
        end
    end

    // read data, zero outside a read answer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // symbol pacing within a token
    usbcf_gap_timer u_symbol_gap (
        .clk(ref_clk),
        .rst_n(rst_n),
        .gap(symgap_q),
        .sent(tx_symbol_done),
        .ready_q(tx_symbol_ok)
    );

    // pacing between tokens
    usbcf_gap_timer u_token_gap (
        .clk(ref_clk),
        .rst_n(rst_n),
        .gap(tokgap_q),
        .sent(tx_token_done),
        .ready_q(tx_token_ok)
    );

    // outputs
    assign cfg_ack = ack_q;
    assign cfg_nack = nack_q;
    assign cfg_rdata = rdata_q;
    assign greeting_strobe = greeting_token_q;
    assign receiver_reset_strobe = rxrst_q;
    assign header_format_select = hdr_q;
    assign node_number_field = node_q;
    assign clock_mhz_field = clk_q;
    assign locked = lock_q;
endmodule

// file: dv/usbcf_node_regs_monitor.sv
`timescale 1ns/1ps
// watches config answers and settings of the node bank
module usbcf_node_regs_monitor (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // request
    input wire logic cfg_req,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    // answer and settings
    input wire logic cfg_ack,
    input wire logic cfg_nack,
    input wire logic [31:0] cfg_rdata,
    input wire logic greeting_strobe,
    input wire logic [15:0] node_number_field,
    input wire logic [6:0] clock_mhz_field,
    input wire logic locked
);
    import usbcf_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // decoded unlocked writes
    wire wr = cfg_req && cfg_write && !locked;
    wire [6:0] cv = cfg_wdata[6:0];
    wire clk_wr = wr && cfg_addr == USBCF_ADDR_CLK;
    wire clk_ok = cv >= USBCF_CLK_MIN && cv <= USBCF_CLK_MAX;
    a_answer_once: assert property (cfg_req |=> cfg_ack != cfg_nack)
        else $error("answer missing or doubled");
    a_lock_blocks: assert property (cfg_req && cfg_write && locked |=> cfg_nack && $stable(node_number_field))
        else $error("write taken while locked");
    a_lock_sticky: assert property (locked |=> locked)
        else $error("lock dropped");
    a_clk_refuse: assert property (clk_wr && !clk_ok |=> cfg_nack && $stable(clock_mhz_field))
        else $error("bad clock value taken");
    a_clk_store: assert property (clk_wr && clk_ok |=> cfg_ack && clock_mhz_field == $past(cv))
        else $error("good clock value lost");
    a_node_store: assert property (wr && cfg_addr == USBCF_ADDR_NODE |=> node_number_field == $past(cfg_wdata[15:0]))
        else $error("node number not stored");
    a_node_rsvd: assert property (cfg_req && !cfg_write && cfg_addr == USBCF_ADDR_NODE
        |=> cfg_rdata == {16'h0000, node_number_field})
        else $error("node read wrong");
    a_greet_pulse: assert property (wr && cfg_addr == USBCF_ADDR_LINK && cfg_wdata[USBCF_GREETING_TOKEN_BIT] |=> greeting_strobe)
        else $error("greeting strobe missing");
    // main scenarios
    c_clk_refused: cover property (clk_wr && !clk_ok);
    c_locked_write: cover property (locked && cfg_req && cfg_write);
    c_greeting: cover property (greeting_strobe);
endmodule

bind usbcf_node_regs usbcf_node_regs_monitor u_usbcf_node_regs_monitor (.ref_clk, .resetn, .cfg_req, .cfg_write,
    .cfg_addr, .cfg_wdata, .cfg_ack, .cfg_nack, .cfg_rdata, .greeting_strobe, .node_number_field, .clock_mhz_field,
    .locked);

// file: dv/usbcf_link_model.sv
`timescale 1ns/1ps
// link-side stand-in: turns bench commands into event pulses and one toggled credit level
module usbcf_link_model (
    // clock and command
    input wire logic ref_clk,
    input wire logic [5:0] go,
    // events toward the bank
    output logic [5:0] ev
);
    initial ev = 6'h00;
    // bit 2 is the issued-credit level, toggled; others pulse
    always @(posedge ref_clk) ev <= #1 {go[5:3], ev[2] ^ go[2], go[1:0]};
endmodule

// file: dv/usbcf_node_regs_bench.sv
`timescale 1ns/1ps
// config transaction sequences against the node bank
module usbcf_node_regs_bench;
    import usbcf_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic cfg_req = 1'b0;
    logic cfg_write = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [31:0] cfg_wdata = 32'h0;
    logic [5:0] go = 6'h00;
    logic [5:0] ev;
    logic cfg_ack, cfg_nack, g_stb, r_stb, sym_ok, tok_ok, hdr, locked;
    logic [31:0] cfg_rdata, rd;
    logic [15:0] node;
    logic [6:0] clkf, e;
    logic [1:0] rsp, stb;
    int bad_count = 0;
    int cmp_count = 0;
    int k;
    logic [6:0] cv [5] = '{7'h04, 7'h05, 7'h64, 7'h65, 7'h00};
    initial forever #20 ref_clk = ~ref_clk;
    usbcf_node_regs u_usbcf_node_regs (.ref_clk, .resetn, .cfg_req, .cfg_write, .cfg_addr, .cfg_wdata, .cfg_ack,
        .cfg_nack, .cfg_rdata, .rx_overflow(ev[0]), .rx_bad_token(ev[1]), .rx_credit_issued(ev[2]),
        .tx_credit_grant(ev[3]), .greeting_strobe(g_stb), .receiver_reset_strobe(r_stb), .tx_symbol_done(ev[4]),
        .tx_token_done(ev[5]), .tx_symbol_ok(sym_ok), .tx_token_ok(tok_ok), .header_format_select(hdr),
        .node_number_field(node), .clock_mhz_field(clkf), .locked);
    usbcf_link_model u_usbcf_link_model (.ref_clk, .go, .ev);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one transaction; the answer stands in the cycle after the request
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk) #1;
        cfg_req = 1'b1;
        cfg_write = w;
        cfg_addr = a;
        cfg_wdata = d;
        @(posedge ref_clk) #1;
        cfg_req = 1'b0;
        rsp = {cfg_nack, cfg_ack};
        rd = cfg_rdata;
        stb = {r_stb, g_stb};
    endtask
    // write with expected answer: 1 ack, 2 nack
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        xfer(1'b1, a, d);
        chk(rsp, r);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        xfer(1'b0, a, 32'h0);
        chk(rsp, 2'b01);
        chk(rd, x);
    endtask
    task automatic pulse(input int n);
        @(posedge ref_clk) #1 go[n] = 1'b1;
        @(posedge ref_clk) #1 go[n] = 1'b0;
    endtask
    // gap g on the token (n=5) or symbol (n=4) pacer, low time counted
    task automatic gapt(input int n, input logic [10:0] g);
        wr(USBCF_ADDR_LINK, (n == 5) ? {21'h1, g} : {10'h0, g, 11'h1}, 2'b01);
        pulse(n);
        repeat (1) @(posedge ref_clk) #1; // just past the edge that takes done
        k = 0;
        while ((n == 5 ? tok_ok : sym_ok) !== 1'b1 && k < 50) begin
            @(posedge ref_clk) #1;
            k++;
        end
        chk(k, g + 1);
        if (k == 50) summarize();
    endtask
    task automatic rst;
        resetn = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 resetn = 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic summarize;
        $display("compared %0d, mismatched %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        rst();
        rdc(USBCF_ADDR_IDENT, 32'h5a000103);
        rdc(USBCF_ADDR_SETUP, 32'h0);
        rdc(USBCF_ADDR_NODE, 32'h0);
        rdc(USBCF_ADDR_CLK, 32'h19);
        rdc(USBCF_ADDR_LINK, 32'h801);
        wr(USBCF_ADDR_CLK, 32'h19, 2'b01);
        wr(USBCF_ADDR_IDENT, 32'hffffffff, 2'b10);
        xfer(1'b0, 8'h10, 32'h0);
        chk(rsp, 2'b10);
        $display("test reset and refusals done");
        wr(USBCF_ADDR_NODE, 32'hffff1234, 2'b01);
        chk(node, 32'h1234);
        rdc(USBCF_ADDR_NODE, 32'h1234);
        wr(USBCF_ADDR_SETUP, 32'h7fffffff, 2'b01);
        chk(hdr, 1'b1);
        rdc(USBCF_ADDR_SETUP, 32'h1);
        e = USBCF_CLK_RESET;
        for (int i = 0; i < 5; i++) begin
            k = cv[i] >= USBCF_CLK_MIN && cv[i] <= USBCF_CLK_MAX;
            wr(USBCF_ADDR_CLK, {25'h1ffffff, cv[i]} & 32'h7f, k ? 2'b01 : 2'b10);
            if (k) e = cv[i];
            chk(clkf, e);
        end
        $display("test settings done");
        pulse(3);
        pulse(0);
        pulse(2);
        @(posedge ref_clk) #1;
        rdc(USBCF_ADDR_LINK, 32'h0e000801);
        wr(USBCF_ADDR_LINK, 32'h01000801, 2'b01);
        chk(stb, 2'b01);
        rdc(USBCF_ADDR_LINK, 32'h0c000801);
        wr(USBCF_ADDR_LINK, 32'h00800801, 2'b01);
        chk(stb, 2'b10);
        rdc(USBCF_ADDR_LINK, 32'h04000801);
        pulse(1);
        rdc(USBCF_ADDR_LINK, 32'h0c000801);
        gapt(5, 11'h3);
        gapt(4, 11'h0);
        $display("test link done");
        wr(USBCF_ADDR_SETUP, 32'h80000000, 2'b01);
        chk(locked, 1'b1);
        wr(USBCF_ADDR_NODE, 32'h5555, 2'b10);
        chk(node, 32'h1234);
        wr(USBCF_ADDR_LINK, 32'h01000801, 2'b10);
        chk(stb, 2'b00);
        wr(USBCF_ADDR_SETUP, 32'h0, 2'b10);
        rdc(USBCF_ADDR_NODE, 32'h1234);
        rdc(USBCF_ADDR_SETUP, 32'h80000000);
        rst();
        chk(locked, 1'b0);
        rdc(USBCF_ADDR_SETUP, 32'h0);
        $display("test lock done");
        summarize();
    end
endmodule
